// ==== edp_defs.vh ====
// Purpose: shared constants of the protected RAM user access block
// Assumes: included by its bare name from every design file
// Notes:   latencies and options are defaults of module parameters
`ifndef EDP_DEFS_VH
`define EDP_DEFS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define EDP_DATA_W      16
`define EDP_CHK_W       5
`define EDP_ADDR_W      8
`define EDP_RAM_DEPTH   256

// ----------------------------------------
// latency and option settings
// ----------------------------------------
`define EDP_ENC_LAT     2
`define EDP_ENC_LAT_MAX 2
`define EDP_DEC_LAT     3
`define EDP_DEC_LAT_MAX 3
`define EDP_RAM_PIPE    1
`define EDP_RAM_PIPE_OFF 0
`define EDP_RAM_PIPE_ON  1
`define EDP_ADDR_ALIGN  1
`define EDP_COPIES      1

// ----------------------------------------
// read result buffer
// ----------------------------------------
`define EDP_FIFO_DEPTH  16
`define EDP_FIFO_CNT_W  5
`define EDP_INFLT_W     4

`endif

// ==== edp_fifo.v ====
// Purpose: synchronous FIFO with registered head for read results
// Assumes: one clock; level counts words held in the array only
// Notes:   total capacity is DEPTH plus the head register
`timescale 1ns/1ps
`include "edp_defs.vh"

module edp_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = `EDP_FIFO_DEPTH,
   parameter CNT_W = `EDP_FIFO_CNT_W,
   parameter PTR_W = 4
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [CNT_W-1:0] level
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [PTR_W-1:0] wr_ptr_ff;
   reg  [PTR_W-1:0] rd_ptr_ff;
   reg  [CNT_W-1:0] cnt_ff;
   reg              head_valid_ff;
   reg  [WIDTH-1:0] head_data_ff;
   wire             push;
   wire             pop;

   assign in_ready  = (cnt_ff < DEPTH);
   assign push      = in_valid & in_ready;
   // head refills when empty or being taken this cycle
   assign pop       = (cnt_ff != {CNT_W{1'b0}}) & (~head_valid_ff | out_ready);
   assign out_valid = head_valid_ff;
   assign out_data  = head_data_ff;
   assign level     = cnt_ff;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr_ff     <= {PTR_W{1'b0}};
         rd_ptr_ff     <= {PTR_W{1'b0}};
         cnt_ff        <= {CNT_W{1'b0}};
         head_valid_ff <= 1'b0;
         head_data_ff  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH - 1) ? {PTR_W{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff     <= (rd_ptr_ff == DEPTH - 1) ? {PTR_W{1'b0}} : rd_ptr_ff + 1'b1;
            head_data_ff  <= mem[rd_ptr_ff];
            head_valid_ff <= 1'b1;
         end else if (out_ready) begin
            head_valid_ff <= 1'b0;
         end
         if (push & ~pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop & ~push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

endmodule

// ==== edp_ram_access.v ====
// Function
// R1: the encoder appends computed Hamming check bits to the user write word to form the codeword.
// R2: encoder latency is 0 to 2 cycles with its stages split around the check-bit logic.
// R3: write address and enable are delayed by the encoder latency so all three reach the RAM together.
// R4: every enabled write cycle writes one word after the encoder delay.
// R5: the whole write path runs on the write clock.
// R6: read address and enable go straight to the RAM and the codeword appears one cycle later.
// R7: the optional RAM output stage adds one read cycle before the decoder.
// R8: the RAM output stage option is 0 for off and 1 for on.
// R9: the decoder corrects the codeword and returns corrected data and corrected check bits apart.
// R10: decoder latency is 0 to 3 read cycles.
// R11: corrected data is valid 1 plus decoder latency plus RAM stage cycles after the read is issued; the ports see it 2 cycles later, via the FIFO.
// R12: with address alignment on, the read address comes out with the data it belongs to.
// R13: the whole read path runs on the read clock.
// R14: user ports exist per copy for up to three copies, only the first when redundancy is off.
// R15: each decoder stage adds exactly one cycle and at most three stages exist.
// R16: user logic presents write word, address and enable together and samples reads at the latency.
// R17: reads and writes on consecutive cycles are taken back to back without stalls; the code stalls reads while user_read_ready is low for FIFO credit.
//
// Purpose: Hamming protected RAM, user write and read paths
// Assumes: one clock serves as both write and read clock
// Notes:   read results pass a 16 word FIFO; reads stall on its credit
`timescale 1ns/1ps
`include "edp_defs.vh"

module edp_ram_access #(
   parameter DW        = `EDP_DATA_W,
   parameter CW        = `EDP_CHK_W,
   parameter AW        = `EDP_ADDR_W,
   parameter DEPTH     = `EDP_RAM_DEPTH,
   parameter ENC_LAT   = `EDP_ENC_LAT,
   parameter DEC_LAT   = `EDP_DEC_LAT,
   parameter RAM_PIPE  = `EDP_RAM_PIPE,
   parameter ALIGN     = `EDP_ADDR_ALIGN,
   parameter COPIES    = `EDP_COPIES,
   parameter FDEPTH    = `EDP_FIFO_DEPTH
) (
   input  wire                 clock,
   input  wire                 rst,
   input  wire [COPIES*DW-1:0] user_write_word,
   input  wire [COPIES*AW-1:0] user_write_addr,
   input  wire [COPIES-1:0]    user_write_en,
   input  wire [COPIES*AW-1:0] user_read_addr,
   input  wire [COPIES-1:0]    user_read_en,
   output wire                 user_read_ready,
   output wire                 read_out_valid,
   input  wire                 read_out_ready,
   output wire [DW-1:0]        read_out_data,
   output wire [CW-1:0]        read_out_parity,
   output wire [AW-1:0]        read_out_addr
);

   localparam NW   = DW + CW;
   localparam PW   = DW + AW + 1 + AW + 1;
   localparam RW   = 1 + AW + NW;
   localparam SW   = RW + CW;
   localparam FW   = DW + CW + AW;
   localparam PRE  = (RAM_PIPE == `EDP_RAM_PIPE_ON ? 1 : 0) + (DEC_LAT > 0 ? 1 : 0);
   localparam DCH  = (DEC_LAT > 1) ? DEC_LAT - 1 : 0;
   localparam IW   = `EDP_INFLT_W;
   localparam LW   = `EDP_FIFO_CNT_W;

   // ----------------------------------------
   // Hamming helpers
   // ----------------------------------------
   function [CW-1:0] hm_check;
      input [DW-1:0] d;
      integer p;
      integer k;
      integer j;
      reg [CW-1:0] acc;
      begin
         acc = {CW{1'b0}};
         k = 0;
         for (p = 1; p <= NW; p = p + 1) begin
            if (((p & (p - 1)) != 0) && (k < DW)) begin
               for (j = 0; j < CW; j = j + 1) begin
                  if (((p >> j) & 1) == 1) begin
                     acc[j] = acc[j] ^ d[k];
                  end
               end
               k = k + 1;
            end
         end
         hm_check = acc;
      end
   endfunction

   // syndrome names the flipped position; a check-bit position leaves data alone
   function [DW-1:0] hm_fix;
      input [DW-1:0] d;
      input [CW-1:0] syn;
      integer p;
      integer k;
      reg [DW-1:0] r;
      begin
         r = d;
         k = 0;
         for (p = 1; p <= NW; p = p + 1) begin
            if (((p & (p - 1)) != 0) && (k < DW)) begin
               if (p == syn) begin
                  r[k] = ~r[k];
               end
               k = k + 1;
            end
         end
         hm_fix = r;
      end
   endfunction

   // ----------------------------------------
   // copy ports and voting
   // ----------------------------------------
   wire [COPIES*PW-1:0] cpack;
   wire [PW-1:0]        voted;
   genvar c;

   // R14: per copy ports
   generate
      for (c = 0; c < COPIES; c = c + 1) begin : g_copy
         assign cpack[c*PW +: PW] = {user_write_word[c*DW +: DW], user_write_addr[c*AW +: AW],
                                     user_write_en[c], user_read_addr[c*AW +: AW], user_read_en[c]};
      end
      if (COPIES == 3) begin : g_vote
         // bitwise majority masks an upset on one copy
         assign voted = (cpack[0 +: PW] & cpack[PW +: PW]) | (cpack[0 +: PW] & cpack[2*PW +: PW]) |
                        (cpack[PW +: PW] & cpack[2*PW +: PW]);
      end else begin : g_single
         assign voted = cpack[0 +: PW];
      end
   endgenerate

   wire [DW-1:0] wr_word = voted[PW-1 -: DW];
   wire [AW-1:0] wr_addr = voted[AW+1+AW+1-1 -: AW];
   wire          wr_en   = voted[AW+1];
   wire [AW-1:0] rd_addr = voted[AW:1];
   wire          rd_en   = voted[0];

   // ----------------------------------------
   // write path
   // ----------------------------------------
   wire [DW+AW:0] enc_in;
   wire [NW+AW:0] enc_out;
   wire [CW-1:0]  enc_chk;

   // R2: first stage ahead of the check logic
   generate
      if (ENC_LAT >= 1) begin : g_enc_s1
         reg [DW+AW:0] s1_ff;
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               s1_ff <= {(DW+AW+1){1'b0}};
            end else begin
               // R3: address and enable ride with the word
               s1_ff <= {wr_en, wr_addr, wr_word};
            end
         end
         assign enc_in = s1_ff;
      end else begin : g_enc_n1
         assign enc_in = {wr_en, wr_addr, wr_word};
      end
   endgenerate

   // R1: codeword is check bits over user word
   assign enc_chk = hm_check(enc_in[DW-1:0]);

   // R2: second stage behind the check logic
   generate
      if (ENC_LAT >= `EDP_ENC_LAT_MAX) begin : g_enc_s2
         reg [NW+AW:0] s2_ff;
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               s2_ff <= {(NW+AW+1){1'b0}};
            end else begin
               s2_ff <= {enc_in[DW+AW:DW], enc_chk, enc_in[DW-1:0]};
            end
         end
         assign enc_out = s2_ff;
      end else begin : g_enc_n2
         assign enc_out = {enc_in[DW+AW:DW], enc_chk, enc_in[DW-1:0]};
      end
   endgenerate

   reg  [NW-1:0] mem [0:DEPTH-1];
   wire          ram_we   = enc_out[NW+AW];
   wire [AW-1:0] ram_wa   = enc_out[NW+AW-1:NW];

   // R4: one word per enabled cycle
   // R5: same clock as the encoder
   always @(posedge clock) begin
      if (ram_we) begin
         mem[ram_wa] <= enc_out[NW-1:0];
      end
   end

   // ----------------------------------------
   // read issue and credit
   // ----------------------------------------
   reg           rdy_ff;
   reg  [IW-1:0] inflight_ff;
   reg  [IW-1:0] nxt_inflight;
   reg           nxt_rdy;
   wire          rd_acc;
   wire          res_valid;
   wire          fifo_in_ready;
   wire [LW-1:0] fifo_level;
   wire          push;

   // R17: back to back while credit remains
   assign rd_acc = rd_en & rdy_ff;
   assign push   = res_valid & fifo_in_ready;

   // ready drops early enough that no result can find the FIFO full
   always @* begin
      nxt_inflight = inflight_ff + {{(IW-1){1'b0}}, rd_acc} - {{(IW-1){1'b0}}, push};
      nxt_rdy      = ({{(8-LW){1'b0}}, fifo_level} + {{(8-IW){1'b0}}, nxt_inflight}) < (FDEPTH - 1);
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rdy_ff      <= 1'b0;
         inflight_ff <= {IW{1'b0}};
      end else begin
         rdy_ff      <= nxt_rdy;
         inflight_ff <= nxt_inflight;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   reg           rv_ff;
   reg  [AW-1:0] ra_ff;
   reg  [NW-1:0] rq_ff;

   // R6: address goes straight in, codeword one cycle later
   // R13: read clock drives the array output
   always @(posedge clock) begin
      if (rd_acc) begin
         rq_ff <= mem[rd_addr];
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rv_ff <= 1'b0;
         ra_ff <= {AW{1'b0}};
      end else begin
         rv_ff <= rd_acc;
         ra_ff <= rd_addr;
      end
   end

   wire [RW*(PRE+1)-1:0] pre_tap;
   wire [SW*(DCH+1)-1:0] dec_tap;
   wire [RW-1:0]         dec_in;
   wire [CW-1:0]         dec_syn;
   wire [SW-1:0]         dec_mid;
   wire [DW-1:0]         fix_data;
   wire [CW-1:0]         fix_chk;
   genvar g;

   assign pre_tap[RW-1:0] = {rv_ff, ra_ff, rq_ff};

   // R7: RAM output stage, then decoder input stage
   // R8: stage present only for setting 1
   generate
      for (g = 0; g < PRE; g = g + 1) begin : g_pre
         reg [RW-1:0] q_ff;
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               q_ff <= {RW{1'b0}};
            end else begin
               q_ff <= pre_tap[RW*g +: RW];
            end
         end
         assign pre_tap[RW*(g+1) +: RW] = q_ff;
      end
   endgenerate

   assign dec_in  = pre_tap[RW*PRE +: RW];
   assign dec_syn = hm_check(dec_in[DW-1:0]) ^ dec_in[NW-1:DW];
   assign dec_tap[SW-1:0] = {dec_in, dec_syn};

   // R10: remaining decoder stages
   // R15: each stage is one cycle
   generate
      for (g = 0; g < DCH; g = g + 1) begin : g_dec
         reg [SW-1:0] q_ff;
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               q_ff <= {SW{1'b0}};
            end else begin
               q_ff <= dec_tap[SW*g +: SW];
            end
         end
         assign dec_tap[SW*(g+1) +: SW] = q_ff;
      end
   endgenerate

   assign dec_mid = dec_tap[SW*DCH +: SW];

   // R9: corrected data and corrected check bits
   assign fix_data  = hm_fix(dec_mid[CW +: DW], dec_mid[CW-1:0]);
   assign fix_chk   = hm_check(fix_data);
   // R11: valid after 1 + decoder latency + RAM stage
   assign res_valid = dec_mid[SW-1];

   wire [AW-1:0] out_addr;

   // R12: address leaves with its data when aligned
   generate
      if (ALIGN == 1) begin : g_align
         assign out_addr = dec_mid[SW-2 -: AW];
      end else begin : g_noalign
         assign out_addr = {AW{1'b0}};
      end
   endgenerate

   // ----------------------------------------
   // result buffer
   // ----------------------------------------
   wire [FW-1:0] fifo_out;

   edp_fifo #(
      .WIDTH (FW),
      .DEPTH (FDEPTH),
      .CNT_W (LW),
      .PTR_W (4)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (res_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ({out_addr, fix_chk, fix_data}),
      .out_valid (read_out_valid),
      .out_ready (read_out_ready),
      .out_data  (fifo_out),
      .level     (fifo_level)
   );

   assign read_out_data   = fifo_out[DW-1:0];
   assign read_out_parity = fifo_out[DW +: CW];
   assign read_out_addr   = fifo_out[DW+CW +: AW];
   assign user_read_ready = rdy_ff;

endmodule

// ==== edp_ram_access_sva.sv ====
// Purpose: port checks of the protected RAM access block
// Assumes: one copy, address alignment on
// Notes:   shadow queue follows issued read addresses
`timescale 1ns/1ps
module edp_ram_access_sva #(
   parameter DW = 16, CW = 5, AW = 8, DEC_LAT = 3, RAM_PIPE = 1, COPIES = 1, FDEPTH = 16
) (
   input wire                 clock,
   input wire                 rst,
   input wire [COPIES*AW-1:0] user_read_addr,
   input wire [COPIES-1:0]    user_read_en,
   input wire                 user_read_ready,
   input wire                 read_out_valid,
   input wire                 read_out_ready,
   input wire [DW-1:0]        read_out_data,
   input wire [CW-1:0]        read_out_parity,
   input wire [AW-1:0]        read_out_addr
);
   localparam int LAT = 1 + DEC_LAT + RAM_PIPE;
   localparam int MAXF = FDEPTH + 2;
   wire take = user_read_en[0] & user_read_ready;
   wire pop = read_out_valid & read_out_ready;
   reg  [5:0]    inflt_ff;
   reg  [4:0]    wp_ff, rp_ff;
   reg  [AW-1:0] aq_ff [0:31];
   wire [5:0]    nxt_inflt = inflt_ff + {5'h00, take} - {5'h00, pop};
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         inflt_ff <= 6'h00;
         wp_ff <= 5'h00;
         rp_ff <= 5'h00;
      end else begin
         inflt_ff <= nxt_inflt;
         wp_ff <= wp_ff + {4'h0, take};
         rp_ff <= rp_ff + {4'h0, pop};
      end
   end
   always @(posedge clock) begin
      if (take)
         aq_ff[wp_ff] <= user_read_addr[AW-1:0];
   end
   function automatic [CW-1:0] chk(input [DW-1:0] d);
      integer i, p, j;
      begin
         chk = {CW{1'b0}};
         p = 2;
         for (i = 0; i < DW; i = i + 1) begin
            p = p + 1;
            // skip check-bit positions
            if ((p & (p - 1)) == 0)
               p = p + 1;
            for (j = 0; j < CW; j = j + 1)
               if (p[j])
                  chk[j] = chk[j] ^ d[i];
         end
      end
   endfunction
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_valid_hold: assert property (read_out_valid && !read_out_ready |=>
      read_out_valid && $stable(read_out_data) && $stable(read_out_addr)) else $error("result dropped");
   a_first_latency: assert property (take && inflt_ff == 6'h00 && !read_out_valid |=>
      (!read_out_valid throughout (1'b1 ##LAT 1'b1)) ##1 read_out_valid) else $error("read latency off");
   a_no_spurious: assert property (read_out_valid |-> inflt_ff != 6'h00)
      else $error("result without read");
   a_addr_order: assert property (read_out_valid |-> read_out_addr == aq_ff[rp_ff])
      else $error("result address or order wrong");
   a_parity_match: assert property (read_out_valid |-> read_out_parity == chk(read_out_data))
      else $error("check bits do not match data");
   a_credit_bound: assert property (inflt_ff <= MAXF)
      else $error("too many reads outstanding");
   a_no_stall: assert property (user_read_ready && inflt_ff < 6'h08 |=> user_read_ready)
      else $error("read stalled early");
   a_ready_release: assert property ($fell(rst) |-> ##[0:2] user_read_ready)
      else $error("ready late after reset");
   c_pop: cover property (pop);
   c_full: cover property (!user_read_ready);
   c_stall: cover property (read_out_valid && !read_out_ready);
endmodule
bind edp_ram_access edp_ram_access_sva #(.DW(DW), .CW(CW), .AW(AW), .DEC_LAT(DEC_LAT),
   .RAM_PIPE(RAM_PIPE), .COPIES(COPIES), .FDEPTH(FDEPTH)) u_edp_ram_access_sva (.clock(clock),
   .rst(rst), .user_read_addr(user_read_addr), .user_read_en(user_read_en),
   .user_read_ready(user_read_ready), .read_out_valid(read_out_valid), .read_out_ready(read_out_ready),
   .read_out_data(read_out_data), .read_out_parity(read_out_parity), .read_out_addr(read_out_addr));

// ==== edp_user_model.sv ====
// Purpose: result consumer on the user side
// Assumes: hold_off from the bench asks for a stall
// Notes:   ready moves just after the edge
`timescale 1ns/1ps
module edp_user_model (
   input  wire clock,
   input  wire rst,
   input  wire hold_off,
   output wire read_out_ready
);
   reg ready_ff;
   assign read_out_ready = ready_ff;
   always @(posedge clock or posedge rst) begin
      if (rst)
         ready_ff <= 1'b0;
      else
         ready_ff <= #1 !hold_off;
   end
endmodule

// ==== edp_ram_access_bench.sv ====
// Purpose: self-checking bench of the protected RAM access block
// Assumes: default widths, decoder 3 stages, RAM stage on
// Notes:   parity is judged by the bound checker
`timescale 1ns/1ps
module edp_ram_access_bench;
   localparam LAT = 1 + 3 + 1;
   reg         clock, rst, hold_off, we, re;
   reg  [15:0] wd;
   reg  [7:0]  wa, ra;
   wire        rdy, ov, ordy;
   wire [15:0] od;
   wire [7:0]  oa;
   integer     n_mismatch, checks, cyc, n_wait;
   reg  [15:0] mem [0:255];
   reg  [23:0] exp_q [$];
   reg  [23:0] got_q [$];
   edp_ram_access #(.DEC_LAT(3), .RAM_PIPE(1)) u_edp_ram_access (.clock(clock), .rst(rst),
      .user_write_word(wd), .user_write_addr(wa), .user_write_en(we), .user_read_addr(ra),
      .user_read_en(re), .user_read_ready(rdy), .read_out_valid(ov), .read_out_ready(ordy),
      .read_out_data(od), .read_out_parity(), .read_out_addr(oa));
   edp_user_model u_edp_user_model (.clock(clock), .rst(rst), .hold_off(hold_off), .read_out_ready(ordy));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (!rst && ov === 1'b1 && ordy === 1'b1)
         got_q.push_back({oa, od});
      if (cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task check(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task step;
      begin
         @(posedge clock);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         we = 1'b1;
         wa = a;
         wd = d;
         mem[a] = d;
         step;
      end
   endtask
   task rd(input [7:0] a);
      begin
         while (rdy !== 1'b1 && n_wait < 100) begin
            re = 1'b0;
            n_wait = n_wait + 1;
            step;
         end
         re = 1'b1;
         ra = a;
         exp_q.push_back({a, mem[a]});
         step;
      end
   endtask
   task expect_all;
      integer k;
      reg [23:0] e, g;
      begin
         k = 0;
         while (got_q.size() < exp_q.size() && k < 200) begin
            step;
            k = k + 1;
         end
         check("count", exp_q.size(), got_q.size());
         while (exp_q.size() > 0 && got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            check("addr", e[23:16], g[23:16]);
            check("data", e[15:0], g[15:0]);
         end
         exp_q.delete();
         got_q.delete();
      end
   endtask
   task t_burst;
      integer i;
      begin
         for (i = 0; i < 32; i = i + 1)
            wr(i[7:0], 16'h9e37 * i[15:0] + 16'h0001);
         wr(8'hff, 16'hffff);
         we = 1'b0;
         // array takes the word two edges after issue, a read on that edge sees old data
         repeat (2) step;
         n_wait = 0;
         rd(8'hff);
         for (i = 0; i < 32; i = i + 1)
            rd(i[7:0]);
         re = 1'b0;
         check("waits", 0, n_wait);
         expect_all;
      end
   endtask
   task t_latency;
      integer k;
      begin
         rd(8'h07);
         re = 1'b0;
         k = 0;
         while (ov !== 1'b1 && k < 20) begin
            step;
            k = k + 1;
         end
         check("latency", LAT + 1, k);
         expect_all;
      end
   endtask
   task t_same_cycle;
      begin
         we = 1'b1;
         wa = 8'h05;
         wd = 16'h5aa5;
         rd(8'h05);
         mem[5] = 16'h5aa5;
         we = 1'b0;
         re = 1'b0;
         // let the encoder delay pass before reading the new word
         repeat (2) step;
         rd(8'h05);
         re = 1'b0;
         expect_all;
      end
   endtask
   task t_fill;
      integer n;
      begin
         hold_off = 1'b1;
         step;
         n = 0;
         re = 1'b1;
         while (rdy === 1'b1 && n < 40) begin
            ra = n[7:0];
            exp_q.push_back({n[7:0], mem[n]});
            step;
            n = n + 1;
         end
         re = 1'b0;
         check("fill", 1, n >= 14 && n <= 17);
         repeat (10) step;
         check("refuse", 0, rdy);
         hold_off = 1'b0;
         expect_all;
         check("empty", 0, ov);
      end
   endtask
   task t_reset_mid;
      begin
         rd(8'h03);
         re = 1'b0;
         step;
         rst = 1'b1;
         step;
         check("valid", 0, ov);
         check("ready", 0, rdy);
         rst = 1'b0;
         repeat (10) step;
         check("stray", 0, got_q.size());
         check("ready", 1, rdy);
         exp_q.delete();
         rd(8'h03);
         re = 1'b0;
         expect_all;
      end
   endtask
   initial begin
      n_mismatch = 0;
      checks = 0;
      cyc = 0;
      n_wait = 0;
      rst = 1'b1;
      hold_off = 1'b0;
      we = 1'b0;
      re = 1'b0;
      wd = 16'h0000;
      wa = 8'h00;
      ra = 8'h00;
      repeat (16) step;
      rst = 1'b0;
      t_burst;
      t_latency;
      t_same_cycle;
      t_fill;
      t_reset_mid;
      give_verdict;
   end
endmodule
